// ---- dsgsr_top.sv ----
`timescale 1ns/1ps
`include "dsgsr_params.svh"

// Notes on behaviour
// R1: deep sleep gate bits 4:0 enable ports E..A
// R2: access to unclocked unit gives bus fault
// R3: all gate bits are zero after reset
// R4: run, sleep, deep tables follow power mode
// R5: sleep tables used only with auto gating
// R6: gate bits 31:5 read zero, ignore writes
// R7: deep sleep gate decoded at offset 0x128
// R8: capability bits mask soft reset writes
// R9: soft reset at 0x040, resets to zero
// R10: bit 20 resets the pwm unit
// R11: bit 16 resets adc module zero
// R12: bit 3 resets the watchdog
// R13: other soft reset bits read zero
// R14: set bit holds unit in reset

module dsgsr_top #(
    parameter int NPORT = `DSGSR_NPORT
) (
    input  wire logic                    mclk_i,
    input  wire logic                    rst_n_i,
    input  wire dsgsr_pkg::dsgsr_avs_req_t avs_req_i,
    output dsgsr_pkg::dsgsr_avs_rsp_t    avs_rsp_o,
    input  wire dsgsr_pkg::dsgsr_pwr_t   pwr_i,
    input  wire logic [NPORT-1:0]        run_clock_gate_two_i,
    input  wire logic [NPORT-1:0]        sleep_clock_gate_two_i,
    input  wire logic [31:0]             device_capabilities_one_i,
    input  wire logic [NPORT-1:0]        unit_access_i,
    output logic      [NPORT-1:0]        port_gate_o,
    output logic      [NPORT-1:0]        unit_bus_fault_o,
    output logic                         pwm_reset_o,
    output logic                         adc0_reset_o,
    output logic                         watchdog_reset_bit_o,
    output logic                         irq_o
);
    import dsgsr_pkg::*;

    // ==========================================================
    // register map, byte offsets from the
    // system control base
    //
    // 0x040  soft reset control zero
    //        bit 20  pwm unit in reset
    //        bit 16  adc module zero in reset
    //        bit 3   watchdog in reset
    //        other bits read zero, writes
    //        to them are dropped; writes are
    //        also masked by the capability
    //        input, so an absent unit can
    //        never be put in reset
    //
    // 0x128  deep sleep clock gate two
    //        bits 4:0 gate ports e..a
    //        bits 31:5 read zero
    //        resets to zero: in deep sleep with
    //        auto gating every port is dark
    //        until software opts in
    //
    // 0x1f0  fault status, one sticky bit
    //        per port, cleared by a read;
    //        the read returns the value
    //        from before the clear
    //
    // 0x1f4  fault mask, same layout; a
    //        set bit lets that port raise
    //        the interrupt
    //
    // any other word answers with a decode
    // error and zero data; writes to it
    // change nothing

    // ==========================================================
    // bus timing
    //
    // idle: waitrequest high. a read or
    // write seen at an idle edge is taken
    // there, a write lands at that edge,
    // and waitrequest drops for exactly the
    // next cycle with readdata and response
    //
    // at the edge where the master sees
    // waitrequest low the old request may
    // still be up, so that edge is ignored;
    // a new request is taken one edge later
    // and back to back transfers cost two
    // cycles each
    //
    // trade-off: the fixed one cycle answer
    // costs a cycle per access but keeps
    // the read mux off the response path,
    // every response bit is a flop
    //
    // byte enables pick the lanes a write
    // replaces, the others keep their old
    // value before the field masks apply;
    // the low two address bits are ignored

    // ==========================================================
    // clock gating and faults
    //
    // the applied enable of a port is the
    // run table while running, the sleep
    // table in sleep and the deep sleep
    // register in deep sleep; both sleep
    // tables count only with auto gating
    // selected, otherwise the run table
    // stays in force in every mode
    //
    // applied enables lag their sources by
    // one edge: a port that software turns
    // on is usable one cycle after the
    // write has been answered
    //
    // an access to a port whose applied
    // enable is low gives a one cycle
    // fault pulse and sets its status bit
    // at the same edge; it is judged on the
    // registered enable, so an access in
    // the cycle that turns a port on still
    // faults
    //
    // a fault and a status read at one edge
    // keep the new fault: set wins over the
    // read clear
    //
    // limitation: this slave is never gated
    // itself, so faults leave on the pulse
    // outputs and never on this bus

    // ==========================================================
    // soft reset outputs
    //
    // each reset output is the register bit
    // itself: the unit stays in reset for as
    // long as the bit is set and is let go
    // by writing the bit back to zero;
    // nothing here pulses or times out
    //
    // the capability mask counts at the
    // write edge only; a later change of
    // that input leaves set bits alone

    // ==========================================================
    // interrupt
    //
    // registered level, high while a status
    // bit is set under a set mask bit; it
    // moves at the same edge as a mask
    // write or a status read, so it never
    // shows a stale level

    // ==========================================================
    // reset and parameters
    //
    // synchronous active low reset: one
    // sampled low edge clears every field,
    // response back to okay with
    // waitrequest high; the first request
    // may rise in the cycle after release
    //
    // the port count NPORT sizes the gate,
    // status and mask fields; the offsets
    // stay put, and ports above bit 4
    // would land in the read zero part of
    // the gate word

    // ==========================================================
    // complete block state
    typedef struct packed {
        dsgsr_state_t    st;
        dsgsr_avs_rsp_t  rsp;
        logic [31:0]     soft_reset_control_zero;
        logic [31:0]     deep_sleep_clock_gate_two;
        logic [NPORT-1:0] fault_status;
        logic [NPORT-1:0] fault_mask;
        logic [NPORT-1:0] port_gate;
        logic [NPORT-1:0] fault;
        logic            irq;
    } dsgsr_state_s_t;

    dsgsr_state_s_t s_reg;
    dsgsr_state_s_t s_next;

    logic [NPORT-1:0] gate_next;
    logic [NPORT-1:0] fault_next;

    // ==========================================================
    // per port table select and fault detect
    dsgsr_gate_select #(
        .NPORT (NPORT)
    ) u_gate_select (
        .run_clock_gate_two_i        (run_clock_gate_two_i),
        .sleep_clock_gate_two_i      (sleep_clock_gate_two_i),
        .deep_sleep_clock_gate_two_i (s_reg.deep_sleep_clock_gate_two[NPORT-1:0]),
        .pwr_i                       (pwr_i),
        .applied_gate_i              (s_reg.port_gate),
        .unit_access_i               (unit_access_i),
        .gate_next_o                 (gate_next),
        .fault_next_o                (fault_next)
    );

    // ==========================================================
    // byte lane merge for partial writes
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [11:0] word_addr;
    logic        req;
    logic        hit_src;
    logic        hit_dsg;
    logic        hit_ist;
    logic        hit_imsk;
    logic [31:0] wmerge;
    logic [31:0] ist_wide;
    logic [31:0] imsk_wide;

    // ==========================================================
    // address decode; low two bits ignored, words are aligned
    always_comb begin
        word_addr = {avs_req_i.address[11:2], 2'b00};
        req       = (avs_req_i.read | avs_req_i.write) & (s_reg.st == DSGSR_IDLE);
        hit_src   = (word_addr == `DSGSR_OFF_SRC);   // see R9
        hit_dsg   = (word_addr == `DSGSR_OFF_DSG);   // see R7
        hit_ist   = (word_addr == `DSGSR_OFF_IST);
        hit_imsk  = (word_addr == `DSGSR_OFF_IMSK);
        ist_wide  = {{(32-NPORT){1'b0}}, s_reg.fault_status};
        imsk_wide = {{(32-NPORT){1'b0}}, s_reg.fault_mask};
        wmerge    = 32'h0000_0000;
        if (hit_src) begin
            wmerge = be_merge(s_reg.soft_reset_control_zero, avs_req_i.writedata, avs_req_i.byteenable);
        end else if (hit_dsg) begin
            wmerge = be_merge(s_reg.deep_sleep_clock_gate_two, avs_req_i.writedata, avs_req_i.byteenable);
        end else if (hit_imsk) begin
            wmerge = be_merge(imsk_wide, avs_req_i.writedata, avs_req_i.byteenable);
        end
    end

    // ==========================================================
    // next state: bus handshake, registers, gating, events
    always_comb begin
        s_next = s_reg;

        // applied clock enables follow the power mode each cycle
        s_next.port_gate = gate_next;   // see R4
        // one cycle fault pulse per offending access
        s_next.fault = fault_next;      // see R2

        case (s_reg.st)
            DSGSR_IDLE: begin
                s_next.rsp.waitrequest = 1'b1;
                if (req) begin
                    // answer in the next cycle with waitrequest low
                    s_next.st              = DSGSR_ACK;
                    s_next.rsp.waitrequest = 1'b0;
                    s_next.rsp.response    = DSGSR_RSP_OKAY;
                    s_next.rsp.readdata    = 32'h0000_0000;
                    if (!(hit_src | hit_dsg | hit_ist | hit_imsk)) begin
                        // unmapped: decode error, data zero
                        s_next.rsp.response = DSGSR_RSP_DECERR;
                    end else if (avs_req_i.read) begin
                        if (hit_src) begin
                            s_next.rsp.readdata = s_reg.soft_reset_control_zero & `DSGSR_SRC_RW_MASK;  // see R13
                        end else if (hit_dsg) begin
                            s_next.rsp.readdata = s_reg.deep_sleep_clock_gate_two & `DSGSR_DSG_RW_MASK;  // see R6
                        end else if (hit_ist) begin
                            s_next.rsp.readdata = ist_wide;
                        end else begin
                            s_next.rsp.readdata = imsk_wide;
                        end
                    end else begin
                        if (hit_src) begin
                            // absent units cannot be put in reset
                            s_next.soft_reset_control_zero =
                                wmerge & device_capabilities_one_i & `DSGSR_SRC_RW_MASK;  // see R8, see R13
                        end else if (hit_dsg) begin
                            s_next.deep_sleep_clock_gate_two = wmerge & `DSGSR_DSG_RW_MASK;  // see R1, see R6
                        end else if (hit_imsk) begin
                            s_next.fault_mask = wmerge[NPORT-1:0];
                        end
                    end
                end
            end
            DSGSR_ACK: begin
                // master releases the request at this edge
                s_next.st              = DSGSR_IDLE;
                s_next.rsp.waitrequest = 1'b1;
            end
            default: begin
                s_next.st              = DSGSR_IDLE;
                s_next.rsp.waitrequest = 1'b1;
            end
        endcase

        // read of the status word clears it, new events win
        if (req && avs_req_i.read && hit_ist) begin
            s_next.fault_status = fault_next;
        end else begin
            s_next.fault_status = s_reg.fault_status | fault_next;
        end

        // level interrupt from the unmasked sticky bits
        s_next.irq = |(s_next.fault_status & s_next.fault_mask);
    end

    // ==========================================================
    // state register; synchronous active low reset
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_reg.st                        <= DSGSR_IDLE;
            s_reg.rsp.readdata              <= 32'h0000_0000;
            s_reg.rsp.response              <= DSGSR_RSP_OKAY;
            s_reg.rsp.waitrequest           <= 1'b1;
            s_reg.soft_reset_control_zero   <= `DSGSR_RST_SRC;  // see R9
            s_reg.deep_sleep_clock_gate_two <= `DSGSR_RST_DSG;  // see R3
            s_reg.fault_status              <= NPORT'(`DSGSR_RST_IST);
            s_reg.fault_mask                <= NPORT'(`DSGSR_RST_IMSK);
            s_reg.port_gate                 <= '0;              // see R3
            s_reg.fault                     <= '0;
            s_reg.irq                       <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs straight from the state flops
    assign avs_rsp_o            = s_reg.rsp;
    assign port_gate_o          = s_reg.port_gate;
    assign unit_bus_fault_o     = s_reg.fault;                                    // see R2
    // units stay in reset for as long as their bit is set
    assign pwm_reset_o          = s_reg.soft_reset_control_zero[`DSGSR_BIT_PWM];  // see R10, see R14
    assign adc0_reset_o         = s_reg.soft_reset_control_zero[`DSGSR_BIT_ADC];  // see R11, see R14
    assign watchdog_reset_bit_o = s_reg.soft_reset_control_zero[`DSGSR_BIT_WDOG]; // see R12, see R14
    assign irq_o                = s_reg.irq;

endmodule

// ---- dsgsr_params.svh ----
`ifndef DSGSR_PARAMS_SVH
`define DSGSR_PARAMS_SVH

// ==========================================================
// bus geometry
`define DSGSR_ADDR_W        12
`define DSGSR_DATA_W        32
`define DSGSR_NPORT         5

// ==========================================================
// register byte offsets from the system control base
`define DSGSR_SYSCTL_BASE   32'h400f_e000
`define DSGSR_OFF_SRC       12'h040
`define DSGSR_OFF_DSG       12'h128
`define DSGSR_OFF_IST       12'h1f0
`define DSGSR_OFF_IMSK      12'h1f4

// ==========================================================
// reset values
`define DSGSR_RST_SRC       32'h0000_0000
`define DSGSR_RST_DSG       32'h0000_0000
`define DSGSR_RST_IST       5'h00
`define DSGSR_RST_IMSK      5'h00

// ==========================================================
// writable bits and field positions
`define DSGSR_SRC_RW_MASK   32'h0011_0008
`define DSGSR_DSG_RW_MASK   32'h0000_001f
`define DSGSR_BIT_PWM       20
`define DSGSR_BIT_ADC       16
`define DSGSR_BIT_WDOG      3

`endif

// ---- dsgsr_pkg.sv ----
package dsgsr_pkg;

    // ==========================================================
    // bus state, gray along idle -> ack -> idle
    typedef enum logic [1:0] {
        DSGSR_IDLE = 2'b00,
        DSGSR_ACK  = 2'b01
    } dsgsr_state_t;

    // ==========================================================
    // avalon response codes
    typedef enum logic [1:0] {
        DSGSR_RSP_OKAY   = 2'b00,
        DSGSR_RSP_SLVERR = 2'b10,
        DSGSR_RSP_DECERR = 2'b11
    } dsgsr_resp_t;

    // ==========================================================
    // avalon-mm request and answer bundles
    typedef struct packed {
        logic [11:0] address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } dsgsr_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        dsgsr_resp_t response;
        logic        waitrequest;
    } dsgsr_avs_rsp_t;

    // ==========================================================
    // power mode seen by the gating logic
    typedef struct packed {
        logic sleep;
        logic deep_sleep;
        logic auto_clock_gating_select;
    } dsgsr_pwr_t;

endpackage

// ---- dsgsr_gate_select.sv ----
`timescale 1ns/1ps

module dsgsr_gate_select #(
    parameter int NPORT = 5
) (
    input  wire logic [NPORT-1:0]  run_clock_gate_two_i,
    input  wire logic [NPORT-1:0]  sleep_clock_gate_two_i,
    input  wire logic [NPORT-1:0]  deep_sleep_clock_gate_two_i,
    input  wire dsgsr_pkg::dsgsr_pwr_t pwr_i,
    input  wire logic [NPORT-1:0]  applied_gate_i,
    input  wire logic [NPORT-1:0]  unit_access_i,
    output logic      [NPORT-1:0]  gate_next_o,
    output logic      [NPORT-1:0]  fault_next_o
);
    import dsgsr_pkg::*;

    logic use_deep;
    logic use_sleep;

    // ==========================================================
    // mode select; sleep tables only count with auto gating on
    always_comb begin
        use_deep  = pwr_i.deep_sleep & pwr_i.auto_clock_gating_select;  // see R5
        use_sleep = pwr_i.sleep & ~pwr_i.deep_sleep & pwr_i.auto_clock_gating_select;  // see R5
    end

    // ==========================================================
    // per port: pick the table and flag accesses to a dark port
    genvar g;
    generate
        for (g = 0; g < NPORT; g = g + 1) begin : g_port
            // deep sleep table, then sleep, else run
            assign gate_next_o[g] = use_deep  ? deep_sleep_clock_gate_two_i[g] :  // see R4
                                    use_sleep ? sleep_clock_gate_two_i[g] :
                                                run_clock_gate_two_i[g];
            // an unclocked port answers any access with a fault
            assign fault_next_o[g] = unit_access_i[g] & ~applied_gate_i[g];  // see R2
        end
    endgenerate

endmodule

// ---- dsgsr_chk_sva.sv ----
`timescale 1ns/1ps

// ==========================================================
// checker on the top-level ports
module dsgsr_chk
    import dsgsr_pkg::*;
#(
    parameter int NPORT = 5
) (
    input wire logic                     mclk_i,
    input wire logic                     rst_n_i,
    input wire dsgsr_pkg::dsgsr_avs_req_t avs_req_i,
    input wire dsgsr_pkg::dsgsr_avs_rsp_t avs_rsp_o,
    input wire dsgsr_pkg::dsgsr_pwr_t    pwr_i,
    input wire logic [NPORT-1:0]         run_clock_gate_two_i,
    input wire logic [NPORT-1:0]         sleep_clock_gate_two_i,
    input wire logic [31:0]              device_capabilities_one_i,
    input wire logic [NPORT-1:0]         unit_access_i,
    input wire logic [NPORT-1:0]         port_gate_o,
    input wire logic [NPORT-1:0]         unit_bus_fault_o,
    input wire logic                     pwm_reset_o,
    input wire logic                     adc0_reset_o,
    input wire logic                     watchdog_reset_bit_o,
    input wire logic                     irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // ==========================================================
    // bus handshake and decode
    a_ack_one_cycle: assert property ($fell(avs_rsp_o.waitrequest) |=> avs_rsp_o.waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_req_answered: assert property ($rose(avs_req_i.read || avs_req_i.write) |-> ##[1:2] !avs_rsp_o.waitrequest)
        else $error("request not answered in time");
    a_unmapped_zero: assert property (!avs_rsp_o.waitrequest && avs_rsp_o.response == DSGSR_RSP_DECERR
        |-> avs_rsp_o.readdata == 32'h0000_0000) else $error("unmapped read not zero");
    // soft reset readback must mirror the unit reset levels
    a_src_readback: assert property (!avs_rsp_o.waitrequest && $past(avs_req_i.read)
        && $past(avs_req_i.address[11:2]) == 10'h010 |-> avs_rsp_o.readdata ==
        {11'h000, pwm_reset_o, 3'h0, adc0_reset_o, 12'h000, watchdog_reset_bit_o, 3'h0})
        else $error("soft reset readback wrong");
    a_dsg_upper_zero: assert property (!avs_rsp_o.waitrequest && $past(avs_req_i.read)
        && $past(avs_req_i.address[11:2]) == 10'h04a |-> avs_rsp_o.readdata[31:5] == 27'h0)
        else $error("deep gate upper bits not zero");
    a_wdog_by_write: assert property ($rose(watchdog_reset_bit_o)
        |-> $past(avs_req_i.write) && $past(device_capabilities_one_i[3]))
        else $error("watchdog reset set without write");

    // ==========================================================
    // gating and faults
    a_run_table: assert property (!pwr_i.auto_clock_gating_select
        |=> port_gate_o == $past(run_clock_gate_two_i))
        else $error("run table not applied");
    a_sleep_table: assert property (pwr_i.auto_clock_gating_select && pwr_i.sleep && !pwr_i.deep_sleep
        |=> port_gate_o == $past(sleep_clock_gate_two_i))
        else $error("sleep table not applied");
    a_fault_pulse: assert property (unit_bus_fault_o == $past(unit_access_i & ~port_gate_o))
        else $error("fault pulse wrong");
    a_irq_cause: assert property ($rose(irq_o) |-> (|unit_bus_fault_o) || $past(avs_req_i.write))
        else $error("irq rose without cause");

    c_fault: cover property (|unit_bus_fault_o);
    c_decerr: cover property (!avs_rsp_o.waitrequest && avs_rsp_o.response == DSGSR_RSP_DECERR);
    c_irq: cover property ($rose(irq_o));
endmodule

bind dsgsr_top dsgsr_chk #(.NPORT(NPORT)) chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_req_i(avs_req_i),
    .avs_rsp_o(avs_rsp_o), .pwr_i(pwr_i), .run_clock_gate_two_i(run_clock_gate_two_i),
    .sleep_clock_gate_two_i(sleep_clock_gate_two_i), .device_capabilities_one_i(device_capabilities_one_i),
    .unit_access_i(unit_access_i), .port_gate_o(port_gate_o), .unit_bus_fault_o(unit_bus_fault_o),
    .pwm_reset_o(pwm_reset_o), .adc0_reset_o(adc0_reset_o), .watchdog_reset_bit_o(watchdog_reset_bit_o),
    .irq_o(irq_o));

// ---- tb.sv ----
`timescale 1ns/1ps

module tb;
    import dsgsr_pkg::*;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] c; logic [31:0] q;
        logic [1:0] r; logic [2:0] s;} dsgsr_tbrow_t;
    logic           mclk_i, rst_n_i;
    dsgsr_avs_req_t req;
    dsgsr_avs_rsp_t rsp;
    dsgsr_pwr_t     pwr;
    logic [4:0]     rcg, scg, acc, gate, flt;
    logic [31:0]    caps, q;
    logic [1:0]     r;
    logic           pwm, adc, wdog, irq;
    int             n_mismatch, checked;
    dsgsr_tbrow_t   rows[6];

    dsgsr_top #(.NPORT(5)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_req_i(req), .avs_rsp_o(rsp),
        .pwr_i(pwr), .run_clock_gate_two_i(rcg), .sleep_clock_gate_two_i(scg),
        .device_capabilities_one_i(caps), .unit_access_i(acc), .port_gate_o(gate), .unit_bus_fault_o(flt),
        .pwm_reset_o(pwm), .adc0_reset_o(adc), .watchdog_reset_bit_o(wdog), .irq_o(irq));

    // ==========================================================
    // clock, watchdog, helpers
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // generous span: whole run is about 150 cycles
    initial begin
        #40000;
        n_mismatch++;
        close_out();
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // master holds the request until waitrequest is sampled low; only the watchdog ends a wait
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        req.address <= a;
        req.read <= !wr;
        req.write <= wr;
        req.writedata <= d;
        do begin
            @(posedge mclk_i);
        end while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        r = rsp.response;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic fault(input logic [4:0] a, input logic [4:0] ef, input logic ei);
        acc <= a;
        @(posedge mclk_i);
        acc <= 5'h00;
        // pulse stands for the cycle after the access edge
        #1;
        chk(flt, ef);
        chk(irq, ei);
        @(posedge mclk_i);
    endtask
    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (20) @(posedge mclk_i);
        chk(gate, 5'h00);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        bus(0, 12'h040, 0);
        chk(q, 32'h0000_0000);
        bus(0, 12'h128, 0);
        chk(q, 32'h0000_0000);
        chk(gate, rcg);
        $display("reset test done");
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        req = '0;
        req.byteenable = 4'hf;
        pwr = '0;
        rcg = 5'h03;
        scg = 5'h0c;
        acc = 5'h00;
        caps = 32'hffff_ffff;
        rst_n_i = 1'b0;
        rows = '{'{12'h128, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_001f, 2'b00, 3'b000},
                 '{12'h040, 32'hffff_ffff, 32'hffff_ffff, 32'h0011_0008, 2'b00, 3'b111},
                 '{12'h040, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0000, 2'b00, 3'b000},
                 '{12'h040, 32'hffff_ffff, 32'h0010_0000, 32'h0010_0000, 2'b00, 3'b100},
                 '{12'h040, 32'h0000_0008, 32'hffff_ffff, 32'h0000_0008, 2'b00, 3'b001},
                 '{12'h128, 32'h0000_0015, 32'hffff_ffff, 32'h0000_0015, 2'b00, 3'b001}};
        do_reset();
        foreach (rows[i]) begin
            caps <= rows[i].c;
            bus(1, rows[i].a, rows[i].d);
            bus(0, rows[i].a, 0);
            chk(q, rows[i].q);
            chk(r, rows[i].r);
            chk({pwm, adc, wdog}, rows[i].s);
        end
        bus(1, 12'h100, 32'h1);
        chk(r, 2'b11);
        bus(0, 12'h100, 0);
        chk(q, 32'h0);
        chk(r, 2'b11);
        // only byte two written: the watchdog bit must survive
        req.byteenable <= 4'h4;
        bus(1, 12'h040, 32'h00ff_0000);
        req.byteenable <= 4'hf;
        bus(0, 12'h040, 0);
        chk(q, 32'h0011_0008);
        $display("register table test done");
        // every power mode against the three tables
        for (int m = 0; m < 8; m++) begin
            pwr <= dsgsr_pwr_t'(m[2:0]);
            repeat (3) @(posedge mclk_i);
            chk(gate, m[0] && m[1] ? 5'h15 : (m[0] && m[2] ? 5'h0c : 5'h03));
        end
        pwr <= '0;
        rcg <= 5'h01;
        repeat (3) @(posedge mclk_i);
        bus(1, 12'h1f4, 32'h1f);
        fault(5'h13, 5'h12, 1'b1);
        bus(0, 12'h1f0, 0);
        chk(q, 32'h12);
        bus(0, 12'h1f0, 0);
        chk(q, 32'h0);
        chk(irq, 1'b0);
        bus(1, 12'h1f4, 32'h0);
        fault(5'h10, 5'h10, 1'b0);
        bus(0, 12'h1f0, 0);
        chk(q, 32'h10);
        $display("gating and fault test done");
        do_reset();
        close_out();
    end
endmodule
